// ---- rtl/airsr_bank.sv ----
`timescale 1ns/1ps
`include "airsr_defines.svh"
module airsr_bank (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // writes to write-only sources elsewhere
   input wire logic rate_src_wr,
   input wire logic fifo1_src_wr,
   input wire logic fifo2_src_wr,
   input wire logic [7:0] src_wdata,
   // power state and interrupt sources
   input wire logic standby_only,
   input wire logic rtc_irq,
   input wire logic aci_event,
   input wire logic mgmt_event,
   input wire logic power_event,
   input wire logic irq9_src,
   input wire logic irq14_src,
   input wire logic irq15_src,
   input wire logic mgmt_pin_active_high,
   input wire logic mgmt_pin_push_pull,
   // floppy pins
   input wire logic head_step_n,
   input wire logic drive_select0_n,
   input wire logic drive_select1_n,
   input wire logic media_changed_in_n,
   output logic media_changed_flag,
   // routing outputs
   output logic parallel_mode,
   output logic firmware_buf_en,
   output logic irq15_out,
   output logic irq15_oe,
   output logic irq14_out,
   output logic irq14_oe,
   output logic rtc_pin_out,
   output logic aci_pin_out,
   output logic aci_pin_oe,
   output logic shared_pin_out,
   output logic shared_pin_oe,
   output logic management_interrupt_n,
   output logic management_interrupt_oe,
   output logic aci_number_override,
   output logic [15:0] frame_request
);
   logic [7:0] route_reg;
   logic [1:0] force_reg;
   logic [7:0] rate_reg;
   logic [7:0] fifo1_reg;
   logic [7:0] fifo2_reg;
   logic [3:0] pins_sync;
   logic step_s;
   logic sel0_s;
   logic sel1_s;
   logic chg_s;
   wire [1:0] force_next;
   wire [1:0] clear_hit;
   wire [1:0] set_hit;
   logic [1:0] sel_pair;
   logic [15:0] frame_next;
   airsr_pkg::airsr_shared_t shared_sel;
   logic aci_level;
   logic mgmt_level;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // pins cross from outside, active-low ones idle high
   airsr_sync #(.WIDTH(4)) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .async_in({media_changed_in_n, drive_select1_n, drive_select0_n, head_step_n}),
      .reset_val(4'hf),
      .sync_out(pins_sync)
   );
   assign step_s = ~pins_sync[0];
   assign sel0_s = ~pins_sync[1];
   assign sel1_s = ~pins_sync[2];
   assign chg_s = ~pins_sync[3];

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         route_reg <= `AIRSR_RST_ROUTE;
      end else if (clk_en && reg_wr && hit(reg_addr, `AIRSR_OFS_ROUTE)) begin
         route_reg <= reg_wdata;
      end
   end

   // one slice per drive; a step and a software set in one cycle: the set wins
   assign sel_pair = {sel1_s, sel0_s};
   for (genvar d = 0; d < 2; d++) begin : g_drive
      assign clear_hit[d] = step_s & sel_pair[d]; // see R15
      assign set_hit[d] = reg_wr & hit(reg_addr, `AIRSR_OFS_FORCE) & reg_wdata[d]; // see R14
      assign force_next[d] = (force_reg[d] & ~clear_hit[d]) | set_hit[d];
      a_force_step_clr: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R15
         (rst_b && clk_en && clear_hit[d] && !set_hit[d]) |=> !force_reg[d])
         else $error("force bit not cleared by step");
      a_force_sw_set: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R14
         (rst_b && clk_en && set_hit[d]) |=> force_reg[d])
         else $error("force bit not set by write");
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         force_reg <= `AIRSR_RST_FORCE;
      end else if (clk_en) begin
         force_reg <= force_next;
      end
   end

   // shadows follow writes to the real sources; the sources stay write-only
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rate_reg <= `AIRSR_RST_SHADOW;
         fifo1_reg <= `AIRSR_RST_SHADOW;
         fifo2_reg <= `AIRSR_RST_SHADOW;
      end else if (clk_en) begin
         if (rate_src_wr) begin
            rate_reg <= src_wdata; // see R18 see R21
         end
         if (fifo1_src_wr) begin
            fifo1_reg <= src_wdata; // see R19 see R21
         end
         if (fifo2_src_wr) begin
            fifo2_reg <= src_wdata; // see R20 see R21
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `AIRSR_OFS_ROUTE: reg_rdata <= route_reg;
               `AIRSR_OFS_FORCE: reg_rdata <= {6'h00, force_reg}; // see R17
               `AIRSR_OFS_RATE: reg_rdata <= rate_reg; // see R18
               `AIRSR_OFS_FIFO1: reg_rdata <= fifo1_reg; // see R19
               `AIRSR_OFS_FIFO2: reg_rdata <= fifo2_reg; // see R20
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         media_changed_flag <= 1'b0;
      end else if (clk_en) begin
         media_changed_flag <= (sel0_s & force_reg[0]) | (sel1_s & force_reg[1]) | chg_s; // see R16
      end
   end

   assign shared_sel = airsr_pkg::airsr_shared_t'(
      route_reg[`AIRSR_F_SHARED_HI:`AIRSR_F_SHARED_LO]); // see R9
   // control interrupt level after polarity, active means asserted
   assign aci_level = route_reg[`AIRSR_B_ACI_POL] ? aci_event : ~aci_event; // see R7
   assign mgmt_level = mgmt_pin_active_high ? mgmt_event : ~mgmt_event; // see R13

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         parallel_mode <= 1'b0;
         firmware_buf_en <= 1'b1;
         irq15_out <= 1'b0;
         irq15_oe <= 1'b0;
         irq14_out <= 1'b0;
         irq14_oe <= 1'b0;
      end else if (clk_en) begin
         parallel_mode <= route_reg[`AIRSR_B_PARALLEL]; // see R1
         firmware_buf_en <= ~route_reg[`AIRSR_B_PARALLEL]; // see R3
         irq15_out <= irq15_src;
         irq15_oe <= route_reg[`AIRSR_B_PARALLEL]; // see R3
         irq14_out <= irq14_src;
         irq14_oe <= route_reg[`AIRSR_B_PARALLEL]; // see R3
      end
   end

   // dedicated pins ignore the parallel mode bit
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rtc_pin_out <= 1'b0;
         aci_pin_out <= 1'b0;
         aci_pin_oe <= 1'b0;
         management_interrupt_n <= 1'b1;
         management_interrupt_oe <= 1'b0;
      end else if (clk_en) begin
         rtc_pin_out <= route_reg[`AIRSR_B_RTC_PIN] & rtc_irq; // see R2 see R4
         aci_pin_out <= aci_level;
         // open drain drives only the low level
         aci_pin_oe <= route_reg[`AIRSR_B_ACI_PIN] &
            (~route_reg[`AIRSR_B_ACI_OD] | ~aci_level); // see R5 see R8
         management_interrupt_n <= mgmt_level;
         management_interrupt_oe <= route_reg[`AIRSR_B_MGMT_PIN] &
            (mgmt_pin_push_pull | ~mgmt_level); // see R12 see R13
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         shared_pin_out <= 1'b1;
         shared_pin_oe <= 1'b0;
         aci_number_override <= 1'b0;
      end else if (clk_en) begin
         aci_number_override <= route_reg[`AIRSR_F_SHARED_LO]; // see R10
         case (shared_sel)
            airsr_pkg::AIRSR_SHARED_PME: begin
               shared_pin_out <= 1'b0;
               shared_pin_oe <= power_event; // see R11
            end
            airsr_pkg::AIRSR_SHARED_ACI: begin
               shared_pin_out <= aci_level;
               shared_pin_oe <= ~route_reg[`AIRSR_B_ACI_OD] | ~aci_level; // see R11
            end
            airsr_pkg::AIRSR_SHARED_IRQ9: begin
               shared_pin_out <= irq9_src;
               shared_pin_oe <= 1'b1; // see R11
            end
            default: begin
               shared_pin_out <= 1'b1;
               shared_pin_oe <= 1'b0;
            end
         endcase
      end
   end

   // frame slots; nothing enters the frame under standby power
   always_comb begin
      frame_next = 16'h0000;
      frame_next[`AIRSR_SLOT_IRQ8] = ~route_reg[`AIRSR_B_RTC_PIN] & rtc_irq; // see R4
      frame_next[`AIRSR_SLOT_IRQ9] = ~route_reg[`AIRSR_B_ACI_PIN] & aci_event; // see R5
      frame_next[`AIRSR_SLOT_IRQ2] = ~route_reg[`AIRSR_B_MGMT_PIN] & mgmt_event; // see R12
      if (standby_only) begin
         frame_next = 16'h0000; // see R6
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         frame_request <= 16'h0000;
      end else if (clk_en) begin
         frame_request <= frame_next;
      end
   end

   a_force_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R14
      (clk_en && reg_wr && reg_addr == `AIRSR_OFS_FORCE && reg_wdata[0]) |=> force_reg[0])
      else $error("force bit 0 not set by write");
   a_force_no_sw_clr: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R14
      (clk_en && force_reg[1] && !(step_s && sel1_s)) |=> force_reg[1])
      else $error("force bit 1 lost without step");
   a_force_hw_clear: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R15
      (clk_en && step_s && sel0_s && !reg_wr) |=> !force_reg[0])
      else $error("force bit 0 not cleared by step");
   a_force_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R17
      (clk_en && reg_rd && reg_addr == `AIRSR_OFS_FORCE) |=> reg_rdata[7:2] == 6'h00)
      else $error("force upper bits not zero");
   a_standby_no_frame: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R6
      (clk_en && standby_only) |=> frame_request == 16'h0000)
      else $error("frame request under standby");
   a_parallel_pins: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R3
      clk_en |=> (irq15_oe == $past(route_reg[`AIRSR_B_PARALLEL])) &&
         (irq14_oe == irq15_oe) && (firmware_buf_en == !irq15_oe))
      else $error("parallel pin takeover mismatch");
   a_irq9_push_pull: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R11
      (clk_en && shared_sel == airsr_pkg::AIRSR_SHARED_IRQ9) |=> shared_pin_oe)
      else $error("irq9 pin not driven");
   a_shadow_capture: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R21
      (clk_en && rate_src_wr) |=> rate_reg == $past(src_wdata))
      else $error("rate shadow missed write");
   a_media_flag: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R16
      (clk_en && chg_s) |=> media_changed_flag)
      else $error("media flag not set by input");

   // routing, media flag and shadow checks, each against the state one cycle earlier
   a_parallel_mode: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R1
      (rst_b && clk_en) |=> parallel_mode == $past(route_reg[`AIRSR_B_PARALLEL]))
      else $error("parallel mode does not follow bit 0");
   a_irq14_pin: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R3
      (rst_b && clk_en) |=> irq14_out == $past(irq14_src))
      else $error("irq14 pin does not follow its source");
   a_rtc_pin_route: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R2
      (rst_b && clk_en) |=>
         rtc_pin_out == ($past(route_reg[`AIRSR_B_RTC_PIN]) && $past(rtc_irq)))
      else $error("clock interrupt pin wrong");
   a_rtc_frame_slot: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R4
      (rst_b && clk_en && !standby_only && !route_reg[`AIRSR_B_RTC_PIN] && rtc_irq) |=>
         frame_request[`AIRSR_SLOT_IRQ8])
      else $error("clock interrupt missing from frame");
   a_rtc_pin_only: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R4
      (rst_b && clk_en && route_reg[`AIRSR_B_RTC_PIN]) |=> !frame_request[`AIRSR_SLOT_IRQ8])
      else $error("pin routed clock interrupt in frame");
   a_aci_frame_slot: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R5
      (rst_b && clk_en && !standby_only && !route_reg[`AIRSR_B_ACI_PIN] && aci_event) |=>
         frame_request[`AIRSR_SLOT_IRQ9])
      else $error("control interrupt missing from frame");
   a_aci_pin_only: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R5
      (rst_b && clk_en && route_reg[`AIRSR_B_ACI_PIN]) |=> !frame_request[`AIRSR_SLOT_IRQ9])
      else $error("pin routed control interrupt in frame");
   a_aci_polarity: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R7
      (rst_b && clk_en) |=>
         aci_pin_out == ($past(route_reg[`AIRSR_B_ACI_POL]) ~^ $past(aci_event)))
      else $error("control interrupt polarity wrong");
   a_aci_open_drain: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R8
      (rst_b && clk_en && route_reg[`AIRSR_B_ACI_OD]) |=> !(aci_pin_oe && aci_pin_out))
      else $error("open drain control pin driven high");
   a_shared_reserved: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R9
      (rst_b && clk_en && shared_sel == airsr_pkg::AIRSR_SHARED_RSVD) |=> !shared_pin_oe)
      else $error("reserved shared pin code drives pin");
   a_aci_override: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R10
      (rst_b && clk_en) |=> aci_number_override == $past(route_reg[`AIRSR_F_SHARED_LO]))
      else $error("number override does not follow bit 5");
   a_pme_open_drain: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R11
      (rst_b && clk_en && shared_sel == airsr_pkg::AIRSR_SHARED_PME) |=>
         !shared_pin_out && (shared_pin_oe == $past(power_event)))
      else $error("power event pin not low open drain");
   a_mgmt_frame_slot: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R12
      (rst_b && clk_en && !standby_only && !route_reg[`AIRSR_B_MGMT_PIN] && mgmt_event) |=>
         frame_request[`AIRSR_SLOT_IRQ2])
      else $error("management interrupt missing from frame");
   a_mgmt_pin_only: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R12
      (rst_b && clk_en && route_reg[`AIRSR_B_MGMT_PIN]) |=> !frame_request[`AIRSR_SLOT_IRQ2])
      else $error("pin routed management interrupt in frame");
   a_mgmt_pin_idle: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R12
      (rst_b && clk_en && !route_reg[`AIRSR_B_MGMT_PIN]) |=> !management_interrupt_oe)
      else $error("management pin driven while in frame");
   a_mgmt_open_drain: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R13
      (rst_b && clk_en && !mgmt_pin_push_pull) |=>
         !(management_interrupt_oe && management_interrupt_n))
      else $error("open drain management pin driven high");
   a_media_drive0: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R16
      (rst_b && clk_en && sel0_s && force_reg[0]) |=> media_changed_flag)
      else $error("media flag not set by drive 0 force");
   a_rate_readback: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R18
      (rst_b && clk_en && reg_rd && reg_addr == `AIRSR_OFS_RATE) |=> reg_rdata == $past(rate_reg))
      else $error("rate shadow read wrong");
   a_fifo1_capture: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R19
      (rst_b && clk_en && fifo1_src_wr) |=> fifo1_reg == $past(src_wdata))
      else $error("first fifo shadow missed write");
   a_fifo2_capture: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R20
      (rst_b && clk_en && fifo2_src_wr) |=> fifo2_reg == $past(src_wdata))
      else $error("second fifo shadow missed write");
endmodule : airsr_bank

// ---- rtl/airsr_defines.svh ----
// Notes on behaviour
// R1: routing bit 0 low means serial frame delivery, high means parallel pins.
// R2: bit 0 leaves clock, control and management interrupt routing alone.
// R3: parallel mode disables firmware buffer; frame and bus-clock pins become IRQ15/IRQ14.
// R4: bit 1 puts the clock interrupt in the frame (0) or on a pin (1).
// R5: bit 2 puts the control interrupt in the frame (0) or on a pin (1).
// R6: no serial-frame interrupts while running from standby power only.
// R7: bit 3 sets control interrupt pin polarity: 0 low, 1 high.
// R8: bit 4 sets control interrupt pin drive: 0 push-pull, 1 open-drain.
// R9: bits 6:5 pick shared pin use: power event, control interrupt, IRQ9.
// R10: with bit 5 set, pin routing overrides the logical device's number.
// R11: shared pin: power event low open-drain; control per bits 3/4; IRQ9 high push-pull.
// R12: bit 7 puts management interrupt in frame slot IRQ2 (0) or on its pin (1).
// R13: management pin polarity and drive come from inputs, default low open-drain.
// R14: force-change bits are set by software writes, never cleared by them.
// R15: each force bit clears on step AND that drive's select.
// R16: media flag = sel0&force0 | sel1&force1 | external media-changed input.
// R17: force register bits 7:2 read as zero.
// R18: floppy rate shadow returns the last written data-rate byte.
// R19: first serial fifo shadow returns the last written fifo control byte.
// R20: second serial fifo shadow uses the same layout for the second port.
// R21: each shadow captures the last write to its write-only source.
`ifndef AIRSR_DEFINES_SVH
`define AIRSR_DEFINES_SVH
`define AIRSR_OFS_ROUTE 8'h00c0
`define AIRSR_OFS_FORCE 8'h00c1
`define AIRSR_OFS_RATE 8'h00c2
`define AIRSR_OFS_FIFO1 8'h00c3
`define AIRSR_OFS_FIFO2 8'h00c4
`define AIRSR_RST_ROUTE 8'h0000
`define AIRSR_RST_FORCE 2'h3
`define AIRSR_RST_SHADOW 8'h0000
`define AIRSR_B_PARALLEL 0
`define AIRSR_B_RTC_PIN 1
`define AIRSR_B_ACI_PIN 2
`define AIRSR_B_ACI_POL 3
`define AIRSR_B_ACI_OD 4
`define AIRSR_F_SHARED_HI 6
`define AIRSR_F_SHARED_LO 5
`define AIRSR_B_MGMT_PIN 7
`define AIRSR_SLOT_IRQ2 4'h0002
`define AIRSR_SLOT_IRQ9 4'h0009
`define AIRSR_SLOT_IRQ8 4'h0008
`endif

// ---- rtl/airsr_pkg.sv ----
package airsr_pkg;
   typedef enum logic [1:0] {
      AIRSR_SHARED_PME = 2'h0,
      AIRSR_SHARED_ACI = 2'h1,
      AIRSR_SHARED_IRQ9 = 2'h2,
      AIRSR_SHARED_RSVD = 2'h3
   } airsr_shared_t;
endpackage : airsr_pkg

// ---- rtl/airsr_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs, held while the enable is low
module airsr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] reset_val,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         meta_reg <= reset_val;
         sync_out <= reset_val;
      end else if (clk_en) begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : airsr_sync

// ---- bench/test_aux_irq_routing_and_shadow_regs.sv ----
`timescale 1ns/1ps
module test_aux_irq_routing_and_shadow_regs;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic rate_src_wr = 1'b0;
   logic fifo1_src_wr = 1'b0;
   logic fifo2_src_wr = 1'b0;
   logic [7:0] src_wdata = 8'h00;
   logic standby_only = 1'b0;
   logic rtc_irq = 1'b0;
   logic aci_event = 1'b0;
   logic mgmt_event = 1'b0;
   logic power_event = 1'b0;
   logic irq9_src = 1'b0;
   logic irq14_src = 1'b0;
   logic irq15_src = 1'b0;
   logic mgmt_pin_active_high = 1'b0;
   logic mgmt_pin_push_pull = 1'b0;
   logic head_step_n = 1'b1;
   logic drive_select0_n = 1'b1;
   logic drive_select1_n = 1'b1;
   logic media_changed_in_n = 1'b1;
   logic media_changed_flag, parallel_mode, firmware_buf_en, irq15_out, irq15_oe;
   logic irq14_out, irq14_oe, rtc_pin_out, aci_pin_out, aci_pin_oe, shared_pin_out;
   logic shared_pin_oe, management_interrupt_n, management_interrupt_oe, aci_number_override;
   logic [15:0] frame_request;
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;

   airsr_bank u_airsr_bank (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rate_src_wr(rate_src_wr), .fifo1_src_wr(fifo1_src_wr),
      .fifo2_src_wr(fifo2_src_wr), .src_wdata(src_wdata), .standby_only(standby_only),
      .rtc_irq(rtc_irq), .aci_event(aci_event), .mgmt_event(mgmt_event),
      .power_event(power_event), .irq9_src(irq9_src), .irq14_src(irq14_src),
      .irq15_src(irq15_src), .mgmt_pin_active_high(mgmt_pin_active_high),
      .mgmt_pin_push_pull(mgmt_pin_push_pull), .head_step_n(head_step_n),
      .drive_select0_n(drive_select0_n), .drive_select1_n(drive_select1_n),
      .media_changed_in_n(media_changed_in_n), .media_changed_flag(media_changed_flag),
      .parallel_mode(parallel_mode), .firmware_buf_en(firmware_buf_en),
      .irq15_out(irq15_out), .irq15_oe(irq15_oe), .irq14_out(irq14_out),
      .irq14_oe(irq14_oe), .rtc_pin_out(rtc_pin_out), .aci_pin_out(aci_pin_out),
      .aci_pin_oe(aci_pin_oe), .shared_pin_out(shared_pin_out),
      .shared_pin_oe(shared_pin_oe), .management_interrupt_n(management_interrupt_n),
      .management_interrupt_oe(management_interrupt_oe),
      .aci_number_override(aci_number_override), .frame_request(frame_request));

   always #2.5 sys_clk = ~sys_clk;

   // a hang costs at most this many cycles; the sequence needs well under a thousand
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail = n_fail + 1;
         conclude();
      end
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe, so it is sampled there
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
   endtask : rd

   // pin inputs pass a two-flop synchroniser, so allow a margin past its lag
   task automatic settle();
      repeat (4) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic route(input logic [7:0] d);
      wr(8'hc0, d);
      settle();
   endtask : route

   task automatic src_wr(input int which, input logic [7:0] d);
      @(posedge sys_clk);
      src_wdata <= d;
      rate_src_wr <= (which == 0);
      fifo1_src_wr <= (which == 1);
      fifo2_src_wr <= (which == 2);
      @(posedge sys_clk);
      rate_src_wr <= 1'b0;
      fifo1_src_wr <= 1'b0;
      fifo2_src_wr <= 1'b0;
   endtask : src_wr

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(8'hc0, 8'h00);
      rd(8'hc1, 8'h03);
      rd(8'h55, 8'h00);
      chk("firmware_buf_en", {15'h0000, firmware_buf_en}, 16'h0001);
      irq15_src <= 1'b1;
      irq14_src <= 1'b1;
      route(8'h01);
      chk("parallel", {12'h000, parallel_mode, firmware_buf_en, irq15_oe, irq14_oe},
          16'h000b);
      chk("irq15_14", {14'h0000, irq15_out, irq14_out}, 16'h0003);
      rtc_irq <= 1'b1;
      aci_event <= 1'b1;
      mgmt_event <= 1'b1;
      settle();
      chk("frame_par", frame_request & 16'h0304, 16'h0304);
      route(8'h00);
      chk("frame_ser", frame_request, 16'h0304);
      standby_only <= 1'b1;
      settle();
      chk("frame_standby", frame_request, 16'h0000);
      standby_only <= 1'b0;
      route(8'h86);
      chk("frame_pins", frame_request, 16'h0000);
      chk("pins", {13'h0000, rtc_pin_out, management_interrupt_n, management_interrupt_oe},
          16'h0005);
      mgmt_pin_active_high <= 1'b1;
      mgmt_pin_push_pull <= 1'b1;
      settle();
      chk("mgmt_high", {14'h0000, management_interrupt_n, management_interrupt_oe},
          16'h0003);
      route(8'h04);
      chk("aci_low_pp", {14'h0000, aci_pin_out, aci_pin_oe}, 16'h0001);
      route(8'h0c);
      chk("aci_high_pp", {14'h0000, aci_pin_out, aci_pin_oe}, 16'h0003);
      route(8'h14);
      chk("aci_od_on", {14'h0000, aci_pin_out, aci_pin_oe}, 16'h0001);
      aci_event <= 1'b0;
      settle();
      chk("aci_od_off", {15'h0000, aci_pin_oe}, 16'h0000);
      power_event <= 1'b1;
      route(8'h00);
      chk("shared_pme", {14'h0000, shared_pin_out, shared_pin_oe}, 16'h0001);
      power_event <= 1'b0;
      settle();
      chk("shared_pme_off", {15'h0000, shared_pin_oe}, 16'h0000);
      aci_event <= 1'b1;
      route(8'h20);
      chk("shared_aci", {13'h0000, shared_pin_out, shared_pin_oe, aci_number_override},
          16'h0003);
      irq9_src <= 1'b1;
      route(8'h40);
      chk("shared_irq9", {13'h0000, shared_pin_out, shared_pin_oe, aci_number_override},
          16'h0006);
      route(8'h60);
      chk("shared_rsvd", {15'h0000, shared_pin_oe}, 16'h0000);
      rd(8'hc0, 8'h60);
      wr(8'hc1, 8'h00);
      rd(8'hc1, 8'h03);
      drive_select1_n <= 1'b0;
      settle();
      chk("media_sel1", {15'h0000, media_changed_flag}, 16'h0001);
      drive_select1_n <= 1'b1;
      drive_select0_n <= 1'b0;
      head_step_n <= 1'b0;
      settle();
      head_step_n <= 1'b1;
      drive_select0_n <= 1'b1;
      settle();
      rd(8'hc1, 8'h02);
      drive_select1_n <= 1'b0;
      head_step_n <= 1'b0;
      settle();
      head_step_n <= 1'b1;
      settle();
      rd(8'hc1, 8'h00);
      chk("media_clear", {15'h0000, media_changed_flag}, 16'h0000);
      media_changed_in_n <= 1'b0;
      settle();
      chk("media_ext", {15'h0000, media_changed_flag}, 16'h0001);
      media_changed_in_n <= 1'b1;
      wr(8'hc1, 8'hfe);
      rd(8'hc1, 8'h02);
      src_wr(0, 8'ha5);
      src_wr(1, 8'h5a);
      src_wr(2, 8'hc3);
      wr(8'hc2, 8'h11);
      rd(8'hc2, 8'ha5);
      rd(8'hc3, 8'h5a);
      rd(8'hc4, 8'hc3);
      src_wr(1, 8'h0f);
      rd(8'hc3, 8'h0f);
      // enable low freezes everything, a register write included
      clk_en <= 1'b0;
      wr(8'hc0, 8'h01);
      clk_en <= 1'b1;
      rd(8'hc0, 8'h60);
      // mid-run reset held two edges, so the state is clean when it lifts
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(8'hc1, 8'h03);
      rd(8'hc0, 8'h00);
      rd(8'hc2, 8'h00);
      conclude();
   end
endmodule : test_aux_irq_routing_and_shadow_regs
